// ==== verilog/bms_top.v ====
// boot and bus mode select block with APB register access
// What this block does
// - three strapped mode pins choose reset vector source and initial bus width
// - pins 000: external vector, 8-bit external bus, external ROM mode
// - pins 001: external vector, 16-bit external bus, external ROM mode
// - byte written to 0x7FF after reset is mode data, held in register
// - bus mode register takes one write per reset, kept until reset
// - captured mode takes effect right after the write completes
// - mode bits 7:6: 00 single-chip, 01 int ROM ext bus, 10 ext ROM
// - pin width used before mode write, area width fields afterwards
// - area 0 register resets to 8-bit width
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "bms_defs.vh"
module bms_top #(
    parameter AREAS = `BMS_AREA_COUNT     // number of chip-select areas
) (
    input  wire        pclk,              // bus clock
    input  wire        presetn,           // async reset, active low
    input  wire        clk_en,            // freezes all state while low
    input  wire        psel,              // apb select
    input  wire        penable,           // apb enable
    input  wire        pwrite,            // apb direction
    input  wire [31:0] paddr,             // apb byte address
    input  wire [31:0] pwdata,            // apb write data
    input  wire [3:0]  pstrb,             // apb byte strobes
    output wire        pready,            // apb ready
    output reg  [31:0] prdata,            // apb read data
    output wire        pslverr,           // apb error
    input  wire        mode_pin_2,        // strap pin, top
    input  wire        mode_pin_1,        // strap pin
    input  wire        mode_pin_0,        // strap pin, bottom
    output reg         ext_vector,        // reset vector fetched externally
    output reg  [1:0]  bus_mode,          // active bus mode
    output reg         mode_written,      // bus mode register has been written
    output reg  [2*AREAS-1:0] area_width  // effective width code per area
);
    localparam [1:0]  ST_BOOT   = 2'h0;
    localparam [1:0]  ST_LIVE   = 2'h1;
    localparam [31:0] MODE_ADDR = `BMS_ADDR_BUS_MODE;
    localparam [31:0] AREA_BASE = `BMS_ADDR_AREA_BASE;
    localparam [31:0] STAT_ADDR = `BMS_ADDR_STATUS;

    reg  [2:0]         pin_meta_reg;
    reg  [2:0]         pin_sync_reg;
    reg  [1:0]         pin_fill_reg;
    reg  [1:0]         pin_fill_next;
    reg  [2:0]         pin_hold_reg;
    reg  [2:0]         pin_hold_next;
    reg                pin_valid_reg;
    reg                pin_valid_next;
    reg  [1:0]         pin_width_reg;
    reg                pin_bad_reg;
    reg  [1:0]         state_reg;
    reg  [1:0]         state_next;
    reg  [1:0]         mode_reg;
    reg  [1:0]         mode_next;
    reg  [1:0]         bus_mode_next;
    reg  [31:0]        rd_next;
    wire [2*AREAS-1:0] area_width_next;
    wire [2*AREAS-1:0] area_flat;
    wire [AREAS-1:0]   area_hit;
    wire               area_any;
    wire               stat_hit;
    wire               dec_ext;
    wire [1:0]         dec_width;
    wire               dec_bad;
    wire               access;
    wire               wr;
    wire               mode_hit;
    wire               mode_wr;
    integer            k;
    genvar             g;

    // zero wait states: every access phase ends at its first edge
    assign pready   = 1'b1;
    assign access   = psel & penable & clk_en;
    assign wr       = access & pwrite;
    // byte at 0x7FF is lane 3 of the word at 0x7FC, so only the word index is compared
    assign mode_hit = (paddr[31:2] == MODE_ADDR[31:2]);
    assign mode_wr  = wr & mode_hit & pstrb[3];
    assign stat_hit = (paddr == STAT_ADDR);
    assign area_any = |area_hit;
    // reading the mode word is refused: it holds write-only bits
    assign pslverr  = psel & penable & ~(mode_hit & pwrite) & ~stat_hit & ~area_any;

    // two flops before anything looks at the straps
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else if (clk_en) begin
            pin_meta_reg <= {mode_pin_2, mode_pin_1, mode_pin_0};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // the synchroniser shows its reset value for two edges, so the latch waits for it to fill
    always @* begin
        pin_fill_next  = pin_fill_reg;
        pin_hold_next  = pin_hold_reg;
        pin_valid_next = pin_valid_reg;
        if (!pin_valid_reg) begin
            if (pin_fill_reg == `BMS_SYNC_FILL) begin
                pin_hold_next  = pin_sync_reg;
                pin_valid_next = 1'b1;
            end else begin
                pin_fill_next = pin_fill_reg + 2'h1;
            end
        end
    end

    // straps are latched once after release, then held until next reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_fill_reg  <= 2'h0;
            pin_hold_reg  <= 3'h0;
            pin_valid_reg <= 1'b0;
        end else if (clk_en) begin
            pin_fill_reg  <= pin_fill_next;
            pin_hold_reg  <= pin_hold_next;
            pin_valid_reg <= pin_valid_next;
        end
    end

    // decoding the next strap value lets the registered outputs change with the latch
    bms_pin_decode u_dec (
        .pins       (pin_hold_next),
        .ext_vector (dec_ext),
        .pin_width  (dec_width),
        .pins_bad   (dec_bad)
    );

    generate
        for (g = 0; g < AREAS; g = g + 1) begin : g_area
            localparam [31:0] AREA_ADDR = AREA_BASE + 4 * g;
            reg  [1:0]        width_reg;
            wire [1:0]        width_next;
            wire              width_wr;
            assign area_hit[g] = (paddr == AREA_ADDR);
            assign width_wr    = wr & pstrb[0] & area_hit[g];
            assign width_next  = width_wr ? pwdata[`BMS_WIDTH_HI_BIT:`BMS_WIDTH_LO_BIT]
                                          : width_reg;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    width_reg <= `BMS_AREA_RESET;
                end else if (clk_en) begin
                    width_reg <= width_next;
                end
            end
            assign area_flat[2*g +: 2] = width_reg;
            // strapped width until the mode write, then each area's own field
            assign area_width_next[2*g +: 2] = (state_next == ST_LIVE) ? width_next
                                                                        : dec_width;
        end
    endgenerate

    always @* begin
        state_next = state_reg;
        mode_next  = mode_reg;
        case (state_reg)
            ST_BOOT: begin
                if (mode_wr) begin
                    state_next = ST_LIVE;
                    // the six reserved bits are dropped; they steer nothing
                    mode_next  = pwdata[24+`BMS_MODE_HI_BIT:24+`BMS_MODE_LO_BIT];
                end
            end
            ST_LIVE: state_next = ST_LIVE;
            default: state_next = ST_BOOT;
        endcase
    end

    // outputs load what the state takes at this edge, so the new mode shows
    // in the cycle right after the write
    always @* begin
        bus_mode_next = `BMS_MODE_SINGLE;
        if (state_next == ST_LIVE)
            bus_mode_next = mode_next;
        else if (dec_ext)
            bus_mode_next = `BMS_MODE_EXT_EXT;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg     <= ST_BOOT;
            mode_reg      <= `BMS_MODE_SINGLE;
            pin_width_reg <= `BMS_WIDTH_8;
            pin_bad_reg   <= 1'b0;
            // straps read 000 until latched: external vector, 8-bit bus
            ext_vector    <= 1'b1;
            bus_mode      <= `BMS_MODE_EXT_EXT;
            mode_written  <= 1'b0;
            area_width    <= {2*AREAS{1'b0}};
        end else if (clk_en) begin
            state_reg     <= state_next;
            mode_reg      <= mode_next;
            pin_width_reg <= dec_width;
            pin_bad_reg   <= dec_bad;
            ext_vector    <= dec_ext;
            bus_mode      <= bus_mode_next;
            mode_written  <= (state_next == ST_LIVE);
            area_width    <= area_width_next;
        end
    end

    // read decode; unmapped words return zero beside the error
    always @* begin
        rd_next = 32'h0000_0000;
        if (stat_hit) begin
            rd_next = {22'h00_0000, pin_bad_reg, pin_hold_reg, mode_reg, mode_written,
                       ext_vector, pin_width_reg};
        end else if (area_any) begin
            for (k = 0; k < AREAS; k = k + 1)
                if (area_hit[k])
                    rd_next = {30'h0000_0000, area_flat[2*k +: 2]};
        end
    end

    // read data is loaded in the setup cycle and stands through the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable) begin
            prdata <= rd_next;
        end
    end
endmodule // bms_top
`default_nettype wire

// ==== verilog/bms_defs.vh ====
// constants for the boot and bus mode select block
`ifndef BMS_DEFS_VH
`define BMS_DEFS_VH
`define BMS_ADDR_BUS_MODE   32'h0000_07FF
`define BMS_ADDR_AREA_BASE  32'h0000_0800
`define BMS_ADDR_STATUS     32'h0000_0820
`define BMS_AREA_COUNT      6
`define BMS_MODE_HI_BIT     7
`define BMS_MODE_LO_BIT     6
`define BMS_MODE_SINGLE     2'h0
`define BMS_MODE_INT_EXT    2'h1
`define BMS_MODE_EXT_EXT    2'h2
`define BMS_MODE_BAD        2'h3
`define BMS_WIDTH_8         2'h0
`define BMS_WIDTH_16        2'h1
`define BMS_WIDTH_32        2'h2
`define BMS_AREA_RESET      2'h0
`define BMS_WIDTH_HI_BIT    1
`define BMS_WIDTH_LO_BIT    0
`define BMS_SYNC_FILL       2'h2
`endif

// ==== verilog/bms_pin_decode.v ====
// decoder of the three strap pins into reset vector source and initial width
`timescale 1ns/100ps
`default_nettype none
`include "bms_defs.vh"
module bms_pin_decode (
    input  wire [2:0] pins,         // synchronised strap value
    output reg        ext_vector,   // reset vector fetched externally
    output reg  [1:0] pin_width,    // initial external bus width code
    output reg        pins_bad      // unsupported strap value
);
    always @* begin
        ext_vector = 1'b0;
        pin_width  = `BMS_WIDTH_8;
        pins_bad   = 1'b0;
        case (pins)
            3'h0: begin
                ext_vector = 1'b1;
                pin_width  = `BMS_WIDTH_8;
            end
            3'h1: begin
                ext_vector = 1'b1;
                pin_width  = `BMS_WIDTH_16;
            end
            3'h3: begin
                ext_vector = 1'b0;
            end
            default: begin
                // 32-bit and top-pin settings are not supported here
                pins_bad   = 1'b1;
                ext_vector = 1'b1;
            end
        endcase
    end
endmodule // bms_pin_decode
`default_nettype wire

// ==== bench/bms_checker.sv ====
// port assertions for the boot and bus mode select block
`timescale 1ns/100ps
`default_nettype none
module bms_checker #(parameter AREAS = 6) (
    input wire logic               pclk,         // clock
    input wire logic               presetn,      // reset
    input wire logic               clk_en,       // enable
    input wire logic               psel,         // select
    input wire logic               penable,      // access
    input wire logic               pwrite,       // write
    input wire logic [31:0]        paddr,        // address
    input wire logic [31:0]        pwdata,       // data
    input wire logic [3:0]         pstrb,        // strobes
    input wire logic               pready,       // ready
    input wire logic               ext_vector,   // vector
    input wire logic [1:0]         bus_mode,     // mode
    input wire logic               mode_written, // written
    input wire logic [2*AREAS-1:0] area_width    // widths
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire       wr = psel && penable && pwrite && clk_en && paddr[31:2] == 30'h0000_01FF
                    && pstrb[3];
    wire [1:0] wmode = pwdata[31:30];
    AST_FIRST_TAKEN: assert property (!mode_written && wr |=> mode_written)
        else $error("mode write not taken");
    AST_MODE_BITS: assert property (!mode_written && wr |=> bus_mode == $past(wmode))
        else $error("mode differs from written bits");
    AST_HELD: assert property (mode_written |=> mode_written)
        else $error("written flag lost");
    AST_LATE_IGNORED: assert property (mode_written && wr |=> $stable(bus_mode))
        else $error("later write changed mode");
    AST_NO_STRAY: assert property (!mode_written && !wr |=> !mode_written)
        else $error("flag set without write");
    AST_PRE_MODE: assert property (!mode_written |-> bus_mode == (ext_vector ? 2'h2 : 2'h0))
        else $error("boot mode not from straps");
    AST_PRE_WIDTH: assert property (!mode_written |-> area_width == {AREAS{area_width[1:0]}})
        else $error("areas differ before write");
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("access phase stretched");
    cover property (wr && !mode_written);
    cover property (wr && mode_written);
    cover property (!ext_vector && !mode_written);
endmodule // bms_checker
bind bms_top bms_checker #(.AREAS(AREAS)) bms_checker_inst (.*);
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the boot and bus mode select block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [3:0]  pstrb = 0;
    logic [2:0]  pins = 0;
    logic        pready, pslverr, ext_vector, mode_written, err;
    logic [1:0]  bus_mode, m;
    logic [11:0] area_width, exp_w;
    logic [2:0]  plist [3] = '{3'h0, 3'h1, 3'h3};
    int          fails = 0, tests_run = 0;
    always #2 pclk = ~pclk;
    bms_top bms_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .mode_pin_2(pins[2]),
        .mode_pin_1(pins[1]), .mode_pin_0(pins[0]), .ext_vector(ext_vector),
        .bus_mode(bus_mode), .mode_written(mode_written), .area_width(area_width));
    // width seen on every area before the mode write, for straps 000 and 001 only
    function automatic logic [11:0] pin_w(input logic [2:0] p);
        return {6{1'b0, p[0]}};
    endfunction
    task automatic wrap_up;
        $display("counts: tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until pready is seen high, then one idle edge
    task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            fails++;
            wrap_up();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rst(input logic [2:0] p);
        presetn <= 1'b0;
        pins <= p;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
    initial begin
        void'($urandom(2684));
        foreach (plist[k]) begin
            rst(plist[k]);
            chk(ext_vector, plist[k] != 3'h3);
            if (plist[k] != 3'h3)
                chk(area_width, pin_w(plist[k]));
            // area 0 left untouched so its reset width shows after the write
            exp_w = 12'h000;
            for (int a = 1; a < 6; a++) begin
                exp_w[2*a +: 2] = 2'($urandom % 3);
                apb(1'b1, 32'h0000_0800 + 4 * a, {30'h0, exp_w[2*a +: 2]}, 4'h1);
            end
            m = 2'(k);
            // a write while the clock enable is low must not count as the mode write
            clk_en <= 1'b0;
            apb(1'b1, 32'h0000_07FC, {2'h1, 30'h0}, 4'h8);
            clk_en <= 1'b1;
            chk(mode_written, 0);
            apb(1'b1, 32'h0000_07FC, {m, 30'h0}, 4'h8);
            chk(mode_written, 1);
            chk(bus_mode, m);
            chk(area_width, exp_w);
            for (int a = 0; a < 6; a++) begin
                apb(1'b0, 32'h0000_0800 + 4 * a, 32'h0000_0000, 4'h0);
                chk(rd, {30'h0, exp_w[2*a +: 2]});
                chk(err, 0);
            end
            apb(1'b1, 32'h0000_07FC, {m == 2'h2 ? 2'h0 : m + 2'h1, 30'h0}, 4'h8);
            chk(bus_mode, m);
            apb(1'b0, 32'h0000_0900, 32'h0000_0000, 4'h0);
            chk(err, 1);
        end
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
